// *** verilog/pioh_pkg.sv ***
// Constants, encodings and carriers for the programming I/O hold block.
// Assumes a single clock domain and a plain strobed register port.
package pioh_pkg;

	localparam int N_PINS = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Per-pin state selection, two bits per pin.
	typedef enum logic [1:0] {
		PIOH_SEL_Z    = 2'h0,
		PIOH_SEL_LOW  = 2'h1,
		PIOH_SEL_HIGH = 2'h3,
		PIOH_SEL_HOLD = 2'h2
	} pioh_sel_t;

	// One pin's scan cells: input, drive enable, output.
	typedef struct packed {
		logic in_cell;
		logic pin_drive_enable_cell;
		logic out_cell;
	} pioh_cells_t;

	// Default cell values per state.
	localparam pioh_cells_t CELLS_Z    = '{in_cell: 1'h1, pin_drive_enable_cell: 1'h0, out_cell: 1'h0};
	localparam pioh_cells_t CELLS_LOW  = '{in_cell: 1'h1, pin_drive_enable_cell: 1'h1, out_cell: 1'h0};
	localparam pioh_cells_t CELLS_HIGH = '{in_cell: 1'h0, pin_drive_enable_cell: 1'h1, out_cell: 1'h1};

	// Register map, byte addresses.
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_SEL    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CUSTEN = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_CELLS  = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PINS   = 8'h14;

	// Control field positions.
	localparam int CTRL_PROG_BIT = 0;
	// Cell register packs three bits per pin: in at 3k+2, enable at 3k+1, out at 3k.
	localparam int CELL_W = 3;
	localparam int SEL_W  = 2;

	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;
	localparam logic [2*N_PINS-1:0] SEL_RESET = 16'h0;

	// Pin pad view carried as a bundle.
	typedef struct packed {
		logic [N_PINS-1:0] o;
		logic [N_PINS-1:0] oe;
	} pioh_pad_t;

	// Register read or write request.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pioh_req_t;

endpackage : pioh_pkg

// *** verilog/pioh_cell.sv ***
// One pin's hold cell: resolves scan cells into a pad drive during programming.
// Assumes prog_mode is already registered and synchronous to clock.
module pioh_cell
	import pioh_pkg::*;
(
	input  wire logic                clock,        // System clock.
	input  wire logic                rst_b,        // Asynchronous reset, active low.
	input  wire logic                prog_mode,    // Programming mode level.
	input  wire pioh_pkg::pioh_sel_t sel,          // Chosen state for this pin.
	input  wire logic                custom,       // Use custom cells instead of defaults.
	input  wire pioh_pkg::pioh_cells_t cust_cells, // Custom cell values.
	input  wire logic                user_o,       // Functional output value.
	input  wire logic                user_oe,      // Functional output enable.
	input  wire logic                pad_i,        // Level seen at the pad.
	output logic                     pad_o,        // Registered pad drive value.
	output logic                     pad_oe,       // Registered pad drive enable.
	output pioh_pkg::pioh_cells_t    cells         // Cells in use, for readback.
);
	pioh_cells_t held;
	pioh_cells_t next_held;
	pioh_cells_t next_cells;
	logic        next_pad_o;
	logic        next_pad_oe;

	always_comb begin
		next_held = held;
		// The last driven state is sampled every cycle outside programming and frozen inside it.
		if (!prog_mode) begin
			next_held = '{in_cell: pad_i, pin_drive_enable_cell: user_oe, out_cell: user_o};
		end
		if (custom) begin
			next_cells = cust_cells;
		end else begin
			case (sel)
				PIOH_SEL_Z:    next_cells = CELLS_Z;
				PIOH_SEL_LOW:  next_cells = CELLS_LOW;
				PIOH_SEL_HIGH: next_cells = CELLS_HIGH;
				PIOH_SEL_HOLD: next_cells = next_held;
				default:       next_cells = CELLS_Z;
			endcase
		end
		if (prog_mode) begin
			// Only enable and output matter; the input cell never reaches the pad.
			next_pad_oe = next_cells.pin_drive_enable_cell;
			next_pad_o  = next_cells.pin_drive_enable_cell & next_cells.out_cell;
		end else begin
			next_pad_oe = user_oe;
			next_pad_o  = user_o;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			held   <= CELLS_Z;
			cells  <= CELLS_Z;
			pad_o  <= 1'h0;
			pad_oe <= 1'h0;
		end else begin
			held   <= next_held;
			cells  <= next_cells;
			pad_o  <= next_pad_o;
			pad_oe <= next_pad_oe;
		end
	end

endmodule : pioh_cell

// *** verilog/pioh_top.sv ***
// Programming I/O hold: per-pin state held on the pads while programming runs.
// Assumes the programmer loads the registers before raising programming mode.
module pioh_top
	import pioh_pkg::*;
(
	input  wire logic                          clock,   // System clock, 10 MHz.
	input  wire logic                          rst_b,   // Asynchronous reset, active low.
	input  wire logic                          reg_wr,  // Register write strobe.
	input  wire logic                          reg_rd,  // Register read strobe.
	input  wire logic [pioh_pkg::ADDR_W-1:0]   reg_addr, // Register byte address.
	input  wire logic [pioh_pkg::DATA_W-1:0]   reg_wdata, // Register write data.
	output logic      [pioh_pkg::DATA_W-1:0]   reg_rdata, // Read data, cycle after strobe.
	input  wire logic [pioh_pkg::N_PINS-1:0]   user_o,  // Functional outputs.
	input  wire logic [pioh_pkg::N_PINS-1:0]   user_oe, // Functional output enables.
	input  wire logic [pioh_pkg::N_PINS-1:0]   pad_i,   // Pad input levels.
	output logic      [pioh_pkg::N_PINS-1:0]   pad_o,   // Pad output values.
	output logic      [pioh_pkg::N_PINS-1:0]   pad_oe,  // Pad output enables, high drives.
	output logic                               prog_active // Programming mode in force.
);
	import pioh_pkg::*;

	localparam int CELLS_W = CELL_W * N_PINS;

	logic              prog_mode;
	logic              next_prog_mode;
	logic [2*N_PINS-1:0] sel_reg;
	logic [2*N_PINS-1:0] next_sel_reg;
	logic [N_PINS-1:0] cust_en;
	logic [N_PINS-1:0] next_cust_en;
	logic [CELLS_W-1:0] cust_reg;
	logic [CELLS_W-1:0] next_cust_reg;
	logic [DATA_W-1:0] next_rdata;
	logic [CELLS_W-1:0] live_cells;
	logic [N_PINS-1:0] cell_o;
	logic [N_PINS-1:0] cell_oe;
	logic              load_ok;

	// Address match shared by the write and read paths.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		hit = (a == r);
	endfunction : hit

	// Selections and cells are frozen while programming so the pads stay put.
	assign load_ok = reg_wr & ~prog_mode;

	always_comb begin
		next_prog_mode = prog_mode;
		next_sel_reg   = sel_reg;
		next_cust_en   = cust_en;
		next_cust_reg  = cust_reg;
		if (reg_wr && hit(reg_addr, REG_CTRL)) begin
			next_prog_mode = reg_wdata[CTRL_PROG_BIT];
		end
		if (load_ok && hit(reg_addr, REG_SEL)) begin
			next_sel_reg = reg_wdata[2*N_PINS-1:0];
		end
		if (load_ok && hit(reg_addr, REG_CUSTEN)) begin
			next_cust_en = reg_wdata[N_PINS-1:0];
		end
		if (load_ok && hit(reg_addr, REG_CELLS)) begin
			next_cust_reg = reg_wdata[CELLS_W-1:0];
		end
	end

	always_comb begin
		next_rdata = ZERO_WORD;
		if (reg_rd) begin
			if (hit(reg_addr, REG_CTRL)) begin
				next_rdata[CTRL_PROG_BIT] = prog_mode;
			end else if (hit(reg_addr, REG_STATUS)) begin
				next_rdata[N_PINS-1:0] = pad_i;
			end else if (hit(reg_addr, REG_SEL)) begin
				next_rdata[2*N_PINS-1:0] = sel_reg;
			end else if (hit(reg_addr, REG_CUSTEN)) begin
				next_rdata[N_PINS-1:0] = cust_en;
			end else if (hit(reg_addr, REG_CELLS)) begin
				next_rdata[CELLS_W-1:0] = live_cells;
			end else if (hit(reg_addr, REG_PINS)) begin
				next_rdata[N_PINS-1:0]        = cell_o;
				next_rdata[2*N_PINS-1:N_PINS] = cell_oe;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prog_mode <= 1'h0;
			sel_reg   <= SEL_RESET;
			cust_en   <= '0;
			cust_reg  <= '0;
			reg_rdata <= ZERO_WORD;
		end else begin
			prog_mode <= next_prog_mode;
			sel_reg   <= next_sel_reg;
			cust_en   <= next_cust_en;
			cust_reg  <= next_cust_reg;
			reg_rdata <= next_rdata;
		end
	end

	assign prog_active = prog_mode;

	genvar g;
	generate
		for (g = 0; g < N_PINS; g++) begin : g_pin
			pioh_cell u_cell (
				.clock      (clock),
				.rst_b      (rst_b),
				.prog_mode  (prog_mode),
				.sel        (pioh_sel_t'(sel_reg[SEL_W*g +: SEL_W])),
				.custom     (cust_en[g]),
				.cust_cells (pioh_cells_t'(cust_reg[CELL_W*g +: CELL_W])),
				.user_o     (user_o[g]),
				.user_oe    (user_oe[g]),
				.pad_i      (pad_i[g]),
				.pad_o      (cell_o[g]),
				.pad_oe     (cell_oe[g]),
				.cells      (live_cells[CELL_W*g +: CELL_W])
			);
		end
	endgenerate

	assign pad_o  = cell_o;
	assign pad_oe = cell_oe;

endmodule : pioh_top

// *** testbench/pioh_top_sva.sv ***
// Checker for the hold block, watching only the top module's ports.
// Assumes one clock and the register map of the package.
module pioh_chk
	import pioh_pkg::*;
(
	input wire logic                        clock,       // Clock.
	input wire logic                        rst_b,       // Reset, active low.
	input wire logic                        reg_wr,      // Write strobe.
	input wire logic                        reg_rd,      // Read strobe.
	input wire logic [pioh_pkg::ADDR_W-1:0] reg_addr,    // Address.
	input wire logic [pioh_pkg::DATA_W-1:0] reg_wdata,   // Write data.
	input wire logic [pioh_pkg::DATA_W-1:0] reg_rdata,   // Read data.
	input wire logic [pioh_pkg::N_PINS-1:0] user_oe,     // User enables.
	input wire logic [pioh_pkg::N_PINS-1:0] pad_i,       // Pad levels.
	input wire logic [pioh_pkg::N_PINS-1:0] pad_o,       // Pad values.
	input wire logic [pioh_pkg::N_PINS-1:0] pad_oe,      // Pad enables.
	input wire logic                        prog_active  // Programming mode.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_rd(logic [7:0] a); reg_rd && reg_addr == a; endsequence
	sequence s_in_prog; prog_active && $past(prog_active); endsequence
	property p_idle; !$past(reg_rd) |-> reg_rdata == ZERO_WORD; endproperty
	property p_ctrl; reg_wr && reg_addr == REG_CTRL |=> prog_active == $past(reg_wdata[0]); endproperty
	property p_z; s_in_prog |-> (pad_o & ~pad_oe) == 8'h00; endproperty
	property p_hold; s_in_prog and $past(prog_active, 2) |-> $stable(pad_o) && $stable(pad_oe); endproperty
	property p_follow; !prog_active && !$past(prog_active) |-> pad_oe == $past(user_oe); endproperty
	property p_status; s_rd(REG_STATUS) |=> reg_rdata == {24'h0, $past(pad_i)}; endproperty
	property p_pins; s_rd(REG_PINS) |=> reg_rdata == {16'h0, $past(pad_oe), $past(pad_o)}; endproperty
	property p_unmap; s_rd(8'h18) |=> reg_rdata == ZERO_WORD; endproperty
	a_idle: assert property (p_idle) else $error("read data not zero");
	a_ctrl: assert property (p_ctrl) else $error("mode flag wrong");
	a_z: assert property (p_z) else $error("undriven pad shows value");
	a_hold: assert property (p_hold) else $error("pads moved in mode");
	a_follow: assert property (p_follow) else $error("pads not following user");
	a_status: assert property (p_status) else $error("status wrong");
	a_pins: assert property (p_pins) else $error("pin readback wrong");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : pioh_chk

bind pioh_top pioh_chk i_chk (.clock, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .user_oe,
	.pad_i, .pad_o, .pad_oe, .prog_active);

// *** testbench/pioh_pad_model.sv ***
// Pad wires seen from outside the device.
// Assumes pad drive and enable come straight from the design.
module pioh_pad_model
	import pioh_pkg::*;
(
	input wire logic                        clock,  // Clock.
	input wire logic [pioh_pkg::N_PINS-1:0] pad_o,  // Pad values.
	input wire logic [pioh_pkg::N_PINS-1:0] pad_oe, // Pad enables.
	output logic     [pioh_pkg::N_PINS-1:0] pad_i   // Wire levels.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N_PINS-1:0] pat = 8'h55;
	// Undriven pads toggle so a stale value never passes as a match.
	always @(posedge clock) pat <= ~pat;
	assign pad_i = (pad_o & pad_oe) | (pat & ~pad_oe);
endmodule : pioh_pad_model

// *** testbench/pioh_top_test.sv ***
// Self-checking bench for the hold block.
// Assumes the pad model on the pins and the checker bound to the top.
module pioh_top_test;
	import pioh_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, prog_active;
	logic [ADDR_W-1:0] reg_addr = 8'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic [N_PINS-1:0] user_o = 8'h0, user_oe = 8'h0, pad_i, pad_o, pad_oe;
	int                miscompares = 0, total_checks = 0;
	always #50 clock = ~clock;
	pioh_top i_dut (.clock, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .user_o, .user_oe,
		.pad_i, .pad_o, .pad_oe, .prog_active);
	pioh_pad_model i_pad (.clock, .pad_o, .pad_oe, .pad_i);
	task automatic chk(input string name, input logic [DATA_W-1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clock);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 0;
		#1 chk("reg_rdata", exp, reg_rdata);
	endtask : rd
	task automatic pads(input logic [N_PINS-1:0] o, oe);
		chk("pad_o", {24'h0, o}, {24'h0, pad_o});
		chk("pad_oe", {24'h0, oe}, {24'h0, pad_oe});
	endtask : pads
	// Pads take the new mode one edge after the control write is sampled; the task waits two.
	task automatic prog(input logic on);
		wr(REG_CTRL, {31'h0, on});
		repeat (2) @(posedge clock);
		#1;
	endtask : prog
	task automatic t_defaults;
		pioh_sel_t         s [3] = '{PIOH_SEL_Z, PIOH_SEL_LOW, PIOH_SEL_HIGH};
		logic [N_PINS-1:0] eo [3] = '{8'h00, 8'h00, 8'hff};
		logic [N_PINS-1:0] ee [3] = '{8'h00, 8'hff, 8'hff};
		for (int i = 0; i < 3; i++) begin
			wr(REG_SEL, {16'h0, {8{s[i]}}});
			prog(1);
			pads(eo[i], ee[i]);
			rd(REG_PINS, {16'h0, ee[i], eo[i]});
			if (i > 0) rd(REG_STATUS, {24'h0, eo[i]});
			prog(0);
		end
		rd(8'h18, ZERO_WORD);
	endtask : t_defaults
	task automatic t_hold;
		@(posedge clock);
		user_o <= 8'h5a;
		user_oe <= 8'hf0;
		wr(REG_SEL, {16'h0, {8{PIOH_SEL_HOLD}}});
		prog(1);
		@(posedge clock);
		user_o <= 8'ha5;
		user_oe <= 8'h0f;
		repeat (4) @(posedge clock);
		#1 pads(8'h50, 8'hf0);
		prog(0);
		pads(8'ha5, 8'h0f);
	endtask : t_hold
	// Pin 0 sets every cell to 1, pin 1 has Z with set don't-care cells.
	task automatic t_custom;
		@(posedge clock);
		user_o <= 8'h00;
		user_oe <= 8'h00;
		wr(REG_SEL, ZERO_WORD);
		wr(REG_CUSTEN, 32'h0000000f);
		wr(REG_CELLS, 32'h000002af);
		prog(1);
		pads(8'h01, 8'h05);
		wr(REG_SEL, 32'h0000ffff);
		rd(REG_CELLS, 32'h009242af);
		rd(REG_SEL, ZERO_WORD);
		rd(REG_CUSTEN, 32'h0000000f);
		rd(REG_CTRL, 32'h00000001);
		pads(8'h01, 8'h05);
		prog(0);
	endtask : t_custom
	task automatic complete_run;
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (16) @(posedge clock);
		rst_b <= 1;
		t_defaults();
		t_hold();
		t_custom();
		complete_run();
	end
	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end
endmodule : pioh_top_test
